/* File: rtl/aws_ctrl.sv */
// Automatic wake/sleep controller with the system control register.
//
// How it works
// - Eight-bit inactivity duration, reset to zero.
// - Count step 320 ms, 640 ms at slowest.
// - Orientation or motion restarts timer and wakes.
// - Sleep and sample-ready events change nothing.
// - Wake needs interrupt enable and wake selection.
// - Asleep, detectors run at the sleep rate.
// - Without auto-sleep, never enter sleep.
// - Every wake/sleep transition raises enabled interrupt.
// - Control layout: sleep, wake, zero, fast, active.
// - Sleep rate codes 50/12.5/6.25/1.56 Hz, override.
// - Wake rate codes 800 down to 1.56 Hz.
// - Active bit zero means standby, default.
// - Fast read skips low bytes on auto-increment.
// - Auto wake/sleep works only with enable set.
// - Unselected motion source is bypassed while asleep.
`timescale 1ns/1ps
module aws_ctrl #(
  parameter int BASE_TICK_CYCLES = aws_pkg::BASE_TICK_CYC
) (
  input  wire logic       SYS_CLK,
  input  wire logic       RST_N,
  input  wire logic       REG_WR_EN,
  input  wire logic       REG_RD_EN,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       ORIENT_EVT,
  input  wire logic       FFMT_EVT,
  output logic      [7:0] REG_RDATA,
  output logic      [7:0] REG_NEXT_ADDR,
  output logic            SAMPLE_TICK,
  output logic      [3:0] RATE_LOG2,
  output logic            ASLEEP,
  output logic            RUNNING,
  output logic            FAST_READ,
  output logic            SLEEP_IRQ
);
  // ==========================================================================
  // Registers
  aws_pkg::aws_ctrl1_t ctrl_q;
  aws_pkg::aws_state_t state_q, state_d;
  logic [7:0]  dur_q, inact_q, wsrc_q, ien_q, rdata_q, naddr_q;
  logic        sleep_en_q, tick_q, asleep_q, run_q, fast_q, irq_q;
  logic [3:0]  rate_q;
  logic [17:0] div_q;
  logic [8:0]  base_cnt_q;
  logic [9:0]  step_q;

  wire wr_dur   = REG_WR_EN && (REG_ADDR == aws_pkg::ADDR_INACT_DUR);
  wire wr_ctrl1 = REG_WR_EN && (REG_ADDR == aws_pkg::ADDR_SYS_CTRL1);
  wire wr_ctrl2 = REG_WR_EN && (REG_ADDR == aws_pkg::ADDR_SYS_CTRL2);
  wire wr_wsrc  = REG_WR_EN && (REG_ADDR == aws_pkg::ADDR_WAKE_SRC);
  wire wr_ien   = REG_WR_EN && (REG_ADDR == aws_pkg::ADDR_INT_EN);
  // Fields other than the active bit are frozen while running, so a host slip cannot retune a live rate.
  wire standby  = !ctrl_q.active;
  aws_pkg::aws_ctrl1_t ctrl_wr;
  assign ctrl_wr = standby ? aws_pkg::aws_ctrl1_t'(REG_WDATA) : ctrl_q;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= aws_pkg::aws_ctrl1_t'(aws_pkg::SYS_CTRL1_RST);
      dur_q  <= aws_pkg::INACT_DUR_RST;
      sleep_en_q <= 1'h0;
      wsrc_q <= 8'h00;
      ien_q  <= 8'h00;
    end else begin
      if (wr_ctrl1) begin
        ctrl_q        <= ctrl_wr;
        ctrl_q.zero   <= 1'h0;
        ctrl_q.active <= REG_WDATA[0];
      end
      if (wr_dur)   dur_q  <= REG_WDATA;
      if (wr_ctrl2) sleep_en_q <= REG_WDATA[aws_pkg::SLEEP_EN_BIT];
      if (wr_wsrc)  wsrc_q <= REG_WDATA;
      if (wr_ien)   ien_q  <= REG_WDATA;
    end
  end

  // ==========================================================================
  // Read path and auto-increment pointer
  logic [7:0] rd_mux;
  assign rd_mux = (REG_ADDR == aws_pkg::ADDR_INACT_DUR) ? dur_q :
                  (REG_ADDR == aws_pkg::ADDR_SYS_CTRL1) ? 8'(ctrl_q) :
                  (REG_ADDR == aws_pkg::ADDR_SYS_CTRL2) ? 8'(sleep_en_q) << aws_pkg::SLEEP_EN_BIT :
                  (REG_ADDR == aws_pkg::ADDR_WAKE_SRC)  ? wsrc_q :
                  (REG_ADDR == aws_pkg::ADDR_INT_EN)    ? ien_q : aws_pkg::RD_UNMAPPED;
  wire msb_xy = (REG_ADDR == aws_pkg::ADDR_X_MSB) || (REG_ADDR == aws_pkg::ADDR_Y_MSB);
  // The last axis wraps to the first in fast read; its low byte is never visited.
  wire [7:0] next_addr = (ctrl_q.fast_read && msb_xy) ? REG_ADDR + aws_pkg::ADDR_STEP_FAST :
                         (ctrl_q.fast_read && REG_ADDR == aws_pkg::ADDR_Z_MSB) ? aws_pkg::ADDR_X_MSB :
                         REG_ADDR + aws_pkg::ADDR_STEP_ONE;
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
      naddr_q <= 8'h00;
    end else if (REG_RD_EN) begin
      rdata_q <= rd_mux;
      naddr_q <= next_addr;
    end
  end

  // ==========================================================================
  // Rate base: one tick per 1.25 ms, then binary division to the selected rate
  wire base_tick = (div_q == 18'(BASE_TICK_CYCLES - 1));
  wire in_sleep  = (state_q == aws_pkg::ST_SLEEP);
  wire in_wake   = (state_q == aws_pkg::ST_WAKE);
  wire [3:0] eff_log2 = in_sleep ? aws_pkg::SLP_LOG2[ctrl_q.sleep_rate_sel]
                                 : aws_pkg::WAKE_LOG2[ctrl_q.wake_rate_sel];
  wire [8:0] rate_mask = 9'((10'h001 << eff_log2) - 10'h001);
  wire sample_tick = base_tick && ((base_cnt_q & rate_mask) == 9'h000) && !standby;

  // ==========================================================================
  // Activity, wake and inactivity timing
  // The sleep-transition and sample-ready sources are deliberately absent from both terms below.
  wire or_en   = ien_q[aws_pkg::IEN_OR_BIT] && ORIENT_EVT;
  wire fm_en   = ien_q[aws_pkg::IEN_FM_BIT] && FFMT_EVT;
  wire restart = or_en || fm_en;
  wire wake_ev = (or_en && wsrc_q[aws_pkg::WAKE_OR_BIT])
              || (fm_en && wsrc_q[aws_pkg::WAKE_FM_BIT]);
  wire [9:0] step_len = (ctrl_q.wake_rate_sel == aws_pkg::WAKE_RATE_SLOWEST) ? aws_pkg::STEP_SLOW_BASE
                                                                            : aws_pkg::STEP_BASE;
  wire step_done = base_tick && (step_q == step_len - 10'h001);
  wire expired   = (inact_q == dur_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      aws_pkg::ST_STANDBY: if (ctrl_q.active) state_d = aws_pkg::ST_WAKE;
      aws_pkg::ST_WAKE: begin
        if (!ctrl_q.active) state_d = aws_pkg::ST_STANDBY;
        else if (sleep_en_q && expired && !restart) state_d = aws_pkg::ST_SLEEP;
      end
      aws_pkg::ST_SLEEP: begin
        if (!ctrl_q.active) state_d = aws_pkg::ST_STANDBY;
        else if (wake_ev || !sleep_en_q) state_d = aws_pkg::ST_WAKE;
      end
      default: state_d = aws_pkg::ST_STANDBY;
    endcase
  end
  wire to_wake  = (state_d == aws_pkg::ST_WAKE) && !in_wake;
  wire clr_tmr  = to_wake || (in_wake && restart);
  wire slp_edge = (in_wake && state_d == aws_pkg::ST_SLEEP) || (in_sleep && state_d == aws_pkg::ST_WAKE);

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q    <= aws_pkg::ST_STANDBY;
      div_q      <= 18'h00000;
      base_cnt_q <= 9'h000;
      step_q     <= 10'h000;
      inact_q    <= 8'h00;
    end else begin
      state_q    <= state_d;
      div_q      <= base_tick ? 18'h00000 : div_q + 18'h00001;
      base_cnt_q <= base_tick ? base_cnt_q + 9'h001 : base_cnt_q;
      if (clr_tmr || !in_wake) begin
        step_q  <= 10'h000;
        inact_q <= 8'h00;
      end else if (step_done) begin
        step_q  <= 10'h000;
        inact_q <= expired ? inact_q : inact_q + 8'h01;
      end else if (base_tick) begin
        step_q  <= step_q + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_q   <= 1'h0;
      rate_q   <= 4'h0;
      asleep_q <= 1'h0;
      run_q    <= 1'h0;
      fast_q   <= 1'h0;
      irq_q    <= 1'h0;
    end else begin
      tick_q   <= sample_tick;
      rate_q   <= eff_log2;
      asleep_q <= state_d == aws_pkg::ST_SLEEP;
      run_q    <= state_d != aws_pkg::ST_STANDBY;
      fast_q   <= ctrl_q.fast_read;
      irq_q    <= slp_edge && ien_q[aws_pkg::IEN_SLP_BIT];
    end
  end
  assign REG_RDATA     = rdata_q;
  assign REG_NEXT_ADDR = naddr_q;
  assign SAMPLE_TICK   = tick_q;
  assign RATE_LOG2     = rate_q;
  assign ASLEEP        = asleep_q;
  assign RUNNING       = run_q;
  assign FAST_READ     = fast_q;
  assign SLEEP_IRQ     = irq_q;

  // ==========================================================================
  // Checks
  sequence s_ctrl_write;
    wr_ctrl1 && standby && !REG_RD_EN;
  endsequence
  sequence s_ctrl_read;
    REG_RD_EN && REG_ADDR == aws_pkg::ADDR_SYS_CTRL1;
  endsequence
  property p_ctrl_readback;
    @(posedge SYS_CLK) disable iff (!RST_N)
    s_ctrl_write ##1 !wr_ctrl1 ##1 s_ctrl_read |=> REG_RDATA == ($past(REG_WDATA, 3) & 8'hFB);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");
  property p_standby;
    @(posedge SYS_CLK) disable iff (!RST_N) !ctrl_q.active |=> state_q == aws_pkg::ST_STANDBY && !RUNNING;
  endproperty
  a_standby: assert property (p_standby) else $error("not standby while inactive");
  property p_no_sleep;
    @(posedge SYS_CLK) disable iff (!RST_N) $rose(in_sleep) |-> $past(sleep_en_q) && $past(in_wake);
  endproperty
  a_no_sleep: assert property (p_no_sleep) else $error("sleep entered without auto-sleep");
  property p_irq;
    @(posedge SYS_CLK) disable iff (!RST_N)
    ($rose(in_sleep) || ($fell(in_sleep) && in_wake)) |-> SLEEP_IRQ == $past(ien_q[aws_pkg::IEN_SLP_BIT]);
  endproperty
  a_irq: assert property (p_irq) else $error("transition interrupt wrong");
  property p_wake;
    @(posedge SYS_CLK) disable iff (!RST_N) in_sleep && ctrl_q.active && wake_ev |=> in_wake && !ASLEEP;
  endproperty
  a_wake: assert property (p_wake) else $error("selected source did not wake");
  property p_bypass;
    @(posedge SYS_CLK) disable iff (!RST_N) in_sleep && sleep_en_q && ctrl_q.active && !wake_ev |=> in_sleep;
  endproperty
  a_bypass: assert property (p_bypass) else $error("unselected source woke device");
  property p_restart;
    @(posedge SYS_CLK) disable iff (!RST_N) in_wake && ctrl_q.active && restart |=> inact_q == 8'h00 && step_q == 10'h000;
  endproperty
  a_restart: assert property (p_restart) else $error("activity did not restart timer");
  property p_wake_clear;
    @(posedge SYS_CLK) disable iff (!RST_N) $rose(in_wake) |-> inact_q == 8'h00 && step_q == 10'h000;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("timer not cleared on wake");
  property p_sleep_rate;
    @(posedge SYS_CLK) disable iff (!RST_N)
    in_sleep && $stable(ctrl_q) |=> RATE_LOG2 == aws_pkg::SLP_LOG2[$past(ctrl_q.sleep_rate_sel)];
  endproperty
  a_sleep_rate: assert property (p_sleep_rate) else $error("sleep rate not applied");
  property p_fast_skip;
    @(posedge SYS_CLK) disable iff (!RST_N)
    REG_RD_EN && ctrl_q.fast_read && REG_ADDR == aws_pkg::ADDR_X_MSB |=> REG_NEXT_ADDR == aws_pkg::ADDR_Y_MSB;
  endproperty
  a_fast_skip: assert property (p_fast_skip) else $error("fast read did not skip low byte");
endmodule : aws_ctrl

/* File: rtl/aws_pkg.sv */
// Constants, field layouts and types of the automatic wake/sleep rate controller.
package aws_pkg;
  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_INACT_DUR  = 8'h29;
  localparam logic [7:0] ADDR_SYS_CTRL1  = 8'h2A;
  localparam logic [7:0] ADDR_SYS_CTRL2  = 8'h2B;
  localparam logic [7:0] ADDR_WAKE_SRC   = 8'h2C;
  localparam logic [7:0] ADDR_INT_EN     = 8'h2D;
  localparam logic [7:0] ADDR_X_MSB      = 8'h01;
  localparam logic [7:0] ADDR_Y_MSB      = 8'h03;
  localparam logic [7:0] ADDR_Z_MSB      = 8'h05;
  localparam logic [7:0] ADDR_STEP_ONE   = 8'h01;
  localparam logic [7:0] ADDR_STEP_FAST  = 8'h02;
  localparam logic [7:0] INACT_DUR_RST   = 8'h00;
  localparam logic [7:0] SYS_CTRL1_RST   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED     = 8'h00;
  // ==========================================================================
  // Field positions
  localparam int SLEEP_EN_BIT  = 2;
  localparam int WAKE_OR_BIT   = 5;
  localparam int WAKE_FM_BIT   = 3;
  localparam int IEN_FM_BIT    = 2;
  localparam int IEN_OR_BIT    = 4;
  localparam int IEN_SLP_BIT   = 7;
  localparam logic [2:0] WAKE_RATE_SLOWEST = 3'h7;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int BASE_TICK_PS   = 1250000000;
  localparam int BASE_TICK_CYC  = BASE_TICK_PS / CLK_PERIOD_PS;
  localparam int STEP_MS        = 320;
  localparam int STEP_SLOW_MS   = 640;
  localparam int BASE_TICK_US   = 1250;
  localparam logic [9:0] STEP_BASE      = 10'(STEP_MS * 1000 / BASE_TICK_US);
  localparam logic [9:0] STEP_SLOW_BASE = 10'(STEP_SLOW_MS * 1000 / BASE_TICK_US);
  // Log2 of base ticks per sample for wake codes 0..7 and sleep codes 0..3.
  localparam logic [3:0] WAKE_LOG2 [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
  localparam logic [3:0] SLP_LOG2  [4] = '{4'h4, 4'h6, 4'h7, 4'h9};
  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] sleep_rate_sel;
    logic [2:0] wake_rate_sel;
    logic       zero;
    logic       fast_read;
    logic       active;
  } aws_ctrl1_t;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'h1,
    ST_WAKE    = 3'h2,
    ST_SLEEP   = 3'h4
  } aws_state_t;
endpackage : aws_pkg

/* File: tb/aws_host_model.sv */
// Host processor model that drives the register port of the controller.
`timescale 1ns/1ps
module aws_host_model (
  input  wire logic       SYS_CLK,
  output logic            REG_WR_EN,
  output logic            REG_RD_EN,
  output logic      [7:0] REG_ADDR,
  output logic      [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic [7:0] REG_NEXT_ADDR
);
  initial begin
    REG_WR_EN = 1'h0;
    REG_RD_EN = 1'h0;
    REG_ADDR  = 8'h00;
    REG_WDATA = 8'h00;
  end
  // ==========================================================================
  // Bus cycles
  // Idle lines show the inverse of the last value, so a stale address can never pass for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge SYS_CLK);
    REG_WR_EN = 1'h1;
    REG_ADDR  = a;
    REG_WDATA = v;
    @(negedge SYS_CLK);
    REG_WR_EN = 1'h0;
    REG_ADDR  = ~a;
    REG_WDATA = ~v;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic [7:0] n);
    @(negedge SYS_CLK);
    REG_RD_EN = 1'h1;
    REG_ADDR  = a;
    @(negedge SYS_CLK);
    REG_RD_EN = 1'h0;
    REG_ADDR  = ~a;
    @(negedge SYS_CLK);
    v = REG_RDATA;
    n = REG_NEXT_ADDR;
  endtask : rd
  // Fields change only in standby, so the control register is written with 00 before the new value.
  task automatic cfg(input logic [7:0] v);
    wr(8'h2A, 8'h00);
    wr(8'h2A, v);
  endtask : cfg
endmodule : aws_host_model

/* File: tb/test_auto_wake_sleep_rate_control.sv */
// Self-checking bench for the automatic wake/sleep rate controller.
`timescale 1ns/1ps
module test_auto_wake_sleep_rate_control;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } aws_row_t;
  logic       sys_clk, rst_n, wr_en, rd_en, orient, ffmt, tick, asleep, running, fast, irq;
  logic [7:0] addr, wdata, rdata, nxt, d, n;
  logic [3:0] rate;
  int         err_total, checks, irq0, i;
  int         irq_n = 0;
  localparam logic [3:0] WLOG [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h9};
  localparam logic [3:0] SLOG [4] = '{4'h4, 4'h6, 4'h7, 4'h9};
  localparam logic [7:0] PA [4] = '{8'h01, 8'h03, 8'h05, 8'h10};
  localparam logic [7:0] PN [4] = '{8'h03, 8'h05, 8'h01, 8'h11};
  localparam aws_row_t ROWS [6] = '{'{8'h29, 8'hA5, 8'hA5}, '{8'h29, 8'hFF, 8'hFF}, '{8'h2A, 8'hFE, 8'hFA},
                                    '{8'h77, 8'h5A, 8'h00}, '{8'h2A, 8'h00, 8'h00}, '{8'h29, 8'h00, 8'h00}};
  // A short base tick keeps one duration step at 1024 clocks instead of 320 ms.
  aws_ctrl #(.BASE_TICK_CYCLES(4)) aws_ctrl_i (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .ORIENT_EVT(orient), .FFMT_EVT(ffmt), .REG_RDATA(rdata), .REG_NEXT_ADDR(nxt),
    .SAMPLE_TICK(tick), .RATE_LOG2(rate), .ASLEEP(asleep), .RUNNING(running), .FAST_READ(fast),
    .SLEEP_IRQ(irq));
  aws_host_model aws_host_model_i (
    .SYS_CLK(sys_clk), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_NEXT_ADDR(nxt));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic to_sleep(input int lo, input int hi);
    int k;
    for (k = 0; k < hi; k++) begin
      @(negedge sys_clk);
      if (asleep === 1'b1) break;
    end
    chk("sleep delay", 8'(k >= lo && k < hi), 8'h01);
    if (k >= hi) conclude();
  endtask : to_sleep
  task automatic gap(input int exp);
    int k;
    for (k = 0; k < 3 * exp && tick !== 1'b1; k++) @(negedge sys_clk);
    for (k = 1; k < 3 * exp; k++) begin
      @(negedge sys_clk);
      if (tick === 1'b1) break;
    end
    chk("tick gap", 8'(k == exp), 8'h01);
    if (k >= 3 * exp) conclude();
  endtask : gap
  task automatic pulse(input logic o, input logic f);
    @(negedge sys_clk);
    orient = o;
    ffmt = f;
    @(negedge sys_clk);
    orient = 1'b0;
    ffmt = 1'b0;
  endtask : pulse
  task automatic go(input logic [7:0] v);
    aws_host_model_i.cfg(v);
    irq0 = irq_n;
    aws_host_model_i.wr(8'h2A, v | 8'h01);
  endtask : go
  // ==========================================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    orient = 1'b0;
    ffmt = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    aws_host_model_i.rd(8'h29, d, n);
    chk("duration reset", d, 8'h00);
    aws_host_model_i.rd(8'h2A, d, n);
    chk("control reset", d, 8'h00);
    chk("running reset", 8'(running), 8'h00);
    foreach (ROWS[r]) begin
      aws_host_model_i.wr(ROWS[r].addr, ROWS[r].wdata);
      aws_host_model_i.rd(ROWS[r].addr, d, n);
      chk("readback", d, ROWS[r].exp);
    end
    aws_host_model_i.rd(8'h01, d, n);
    chk("normal pointer", n, 8'h02);
    aws_host_model_i.wr(8'h2A, 8'h02);
    for (i = 0; i < 4; i++) begin
      aws_host_model_i.rd(PA[i], d, n);
      chk("fast pointer", n, PN[i]);
    end
    chk("fast read", 8'(fast), 8'h01);
    for (i = 0; i < 8; i++) begin
      go({2'h0, 3'(i), 3'h0});
      repeat (4) @(negedge sys_clk);
      chk("running", 8'(running), 8'h01);
      chk("wake rate", 8'(rate), 8'(WLOG[i]));
    end
    repeat (200) @(negedge sys_clk);
    chk("no sleep", 8'(asleep), 8'h00);
    chk("fast read off", 8'(fast), 8'h00);
    aws_host_model_i.wr(8'h2B, 8'h04);
    aws_host_model_i.wr(8'h2D, 8'h80);
    for (i = 0; i < 4; i++) begin
      go({2'(i), 6'h00});
      to_sleep(0, 40);
      repeat (2) @(negedge sys_clk);
      chk("sleep rate", 8'(rate), 8'(SLOG[i]));
      chk("sleep irq", 8'(irq_n - irq0), 8'h01);
    end
    gap(2048);
    aws_host_model_i.wr(8'h29, 8'h01);
    go(8'h00);
    to_sleep(900, 1300);
    go(8'h38);
    to_sleep(1900, 2400);
    aws_host_model_i.wr(8'h2D, 8'h84);
    go(8'h00);
    gap(4);
    repeat (500) @(negedge sys_clk);
    pulse(1'b0, 1'b1);
    to_sleep(900, 1300);
    aws_host_model_i.wr(8'h2C, 8'h20);
    aws_host_model_i.wr(8'h2D, 8'h94);
    irq0 = irq_n;
    pulse(1'b1, 1'b0);
    repeat (2) @(negedge sys_clk);
    chk("orient wake", 8'(asleep), 8'h00);
    chk("wake irq", 8'(irq_n - irq0), 8'h01);
    to_sleep(900, 1300);
    pulse(1'b0, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk("motion unselected", 8'(asleep), 8'h01);
    aws_host_model_i.wr(8'h2D, 8'h84);
    pulse(1'b1, 1'b0);
    repeat (3) @(negedge sys_clk);
    chk("orient disabled", 8'(asleep), 8'h01);
    aws_host_model_i.wr(8'h2C, 8'h08);
    aws_host_model_i.wr(8'h2D, 8'h04);
    irq0 = irq_n;
    pulse(1'b0, 1'b1);
    repeat (3) @(negedge sys_clk);
    chk("motion wake", 8'(asleep), 8'h00);
    to_sleep(900, 1300);
    chk("irq masked", 8'(irq_n - irq0), 8'h00);
    aws_host_model_i.wr(8'h2A, 8'hFF);
    aws_host_model_i.rd(8'h2A, d, n);
    chk("locked fields", d, 8'h01);
    conclude();
  end
endmodule : test_auto_wake_sleep_rate_control
